/* File: anps_regs.sv */
// auto-negotiation advertisement, partner ability and expansion registers on APB
// Overview of operation
// [RULE_01] transmit local selector, reset to 802.3 code
// [RULE_02] load partner register from received code word
// [RULE_03] software trusts partner data after completion
// [RULE_04] partner next-page flag in bit 15
// [RULE_05] partner acknowledge in bit 14
// [RULE_06] partner remote fault in bit 13
// [RULE_07] partner technology abilities in bits 8:5
// [RULE_08] partner 100BASE-T4 bit reads zero
// [RULE_09] partner bits 12:10 read zero
// [RULE_10] software writes reserved bits at defaults
// [RULE_11] partner selector in bits 4:0
// [RULE_12] expansion bits 15:5 read zero
// [RULE_13] override-write bits need override bit set
// [RULE_14] expansion bit 3: partner next-page able
// [RULE_15] expansion bit 2 reads one
// [RULE_16] expansion bit 1 latches page received
// [RULE_17] expansion read clears page received
// [RULE_18] expansion bit 4 latches parallel fault
// [RULE_19] expansion bit 0 follows valid pulse bursts
// [RULE_20] latched bits hold until register read
`timescale 1ns/1ps
`default_nettype none
module anps_regs
(
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [anps_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [anps_pkg::DATA_W-1:0]       pwdata,
	output logic      [anps_pkg::DATA_W-1:0]       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              lcw_valid,
	input  wire logic [anps_pkg::REG_W-1:0]        lcw_data,
	input  wire logic                              flp_ok,
	input  wire logic                              pd_fault,
	output logic      [anps_pkg::SEL_W-1:0]        adv_selector
);
	typedef struct packed
	{
		logic [anps_pkg::REG_W-1:0]  lpa;
		logic                        lp_np_able;
		logic                        lp_an_able;
		logic                        override;
		logic [anps_pkg::DATA_W-1:0] rdata;
		logic                        ready;
		logic                        slverr;
		logic                        snap_page;
		logic                        snap_fault;
		logic                        exp_read;
	} anps_state_t;

	anps_state_t st_reg;
	anps_state_t st_next;

	logic                         setup;
	logic                         done;
	logic                         wr_done;
	logic                         exp_clr;
	logic                         page_flag;
	logic                         fault_flag;
	logic [anps_pkg::SEL_W-1:0]   sel_q;
	logic [anps_pkg::REG_W-1:0]   exp_word;
	logic [anps_pkg::REG_W-1:0]   adv_word;
	logic [anps_pkg::REG_W-1:0]   ovr_word;
	logic [anps_pkg::REG_W-1:0]   rd_word;
	logic                         hit;

	assign setup   = psel & ~penable;
	assign done    = psel & penable & st_reg.ready;
	assign wr_done = done & pwrite;
	// clear only what the master actually saw set, so a new event is not lost
	assign exp_clr = done & ~pwrite & st_reg.exp_read; // [RULE_17]

	anps_cw_field #(
		.W     (anps_pkg::SEL_W),
		.RESET (anps_pkg::ADV_SEL_RESET)
	) u_adv_sel (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_done && paddr == anps_pkg::ADDR_ADV),
		.override (st_reg.override),
		.wr_data  (pwdata[anps_pkg::SEL_W-1:0]),
		.value    (sel_q)
	); // [RULE_01]

	anps_lh_flag u_page_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (lcw_valid),
		.clr_req (exp_clr & st_reg.snap_page),
		.flag    (page_flag)
	); // [RULE_16] [RULE_17]

	anps_lh_flag u_pd_fault (
		.pclk    (pclk),
		.presetn (presetn),
		.set_evt (pd_fault),
		.clr_req (exp_clr & st_reg.snap_fault),
		.flag    (fault_flag)
	); // [RULE_18]

	always_comb
	begin
		exp_word = '0; // [RULE_12]
		exp_word[anps_pkg::EXP_PD_FAULT] = fault_flag; // [RULE_18]
		exp_word[anps_pkg::EXP_LP_NP]    = st_reg.lp_np_able; // [RULE_14]
		exp_word[anps_pkg::EXP_NP_ABLE]  = anps_pkg::NP_ABLE_VAL; // [RULE_15]
		exp_word[anps_pkg::EXP_PAGE_RX]  = page_flag; // [RULE_16]
		exp_word[anps_pkg::EXP_LP_AN]    = st_reg.lp_an_able; // [RULE_19]
		adv_word = '0;
		adv_word[anps_pkg::SEL_W-1:0] = sel_q;
		ovr_word = '0;
		ovr_word[anps_pkg::OVR_BIT] = st_reg.override;
		hit = 1'b1;
		case (paddr)
			anps_pkg::ADDR_ADV: rd_word = adv_word;
			// masking keeps reserved and T4 bits at zero on every read
			anps_pkg::ADDR_LPA: rd_word = st_reg.lpa & anps_pkg::LPA_KEEP_MASK; // [RULE_08] [RULE_09]
			anps_pkg::ADDR_EXP: rd_word = exp_word;
			anps_pkg::ADDR_OVR: rd_word = ovr_word;
			default:
			begin
				rd_word = '0;
				hit = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		st_next = st_reg;
		// zero-wait slave: ready rises for the single access cycle
		st_next.ready  = setup;
		st_next.slverr = setup & ~hit;
		if (setup)
		begin
			st_next.rdata      = pwrite ? '0 : {16'h0000, rd_word};
			st_next.exp_read   = ~pwrite & (paddr == anps_pkg::ADDR_EXP);
			st_next.snap_page  = page_flag;
			st_next.snap_fault = fault_flag;
		end
		else if (done)
			st_next.exp_read = 1'b0;
		st_next.lp_an_able = flp_ok; // [RULE_19]
		if (wr_done && paddr == anps_pkg::ADDR_OVR)
			st_next.override = pwdata[anps_pkg::OVR_BIT];
		if (wr_done && paddr == anps_pkg::ADDR_LPA && st_reg.override) // [RULE_13]
			st_next.lpa[anps_pkg::LPA_SEL_CW_W-1:0] = pwdata[anps_pkg::LPA_SEL_CW_W-1:0];
		// received word wins over a same-cycle override write
		if (lcw_valid)
		begin
			st_next.lpa        = lcw_data & anps_pkg::LPA_KEEP_MASK; // [RULE_02] [RULE_04] [RULE_05] [RULE_06] [RULE_07] [RULE_11]
			st_next.lp_np_able = lcw_data[anps_pkg::LPA_NEXT_PAGE]; // [RULE_14]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg          <= '0;
			st_reg.lpa      <= anps_pkg::LPA_RESET;
			st_reg.override <= anps_pkg::OVR_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign prdata       = st_reg.rdata;
	assign pready       = st_reg.ready;
	assign pslverr      = st_reg.slverr;
	assign adv_selector = sel_q;
endmodule // anps_regs
`default_nettype wire

/* File: anps_pkg.sv */
// constants for the auto-negotiation partner status register bank
package anps_pkg;
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned REG_W     = 16;
	localparam int unsigned SEL_W     = 5;
	// register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_ADV = 8'h04;
	localparam logic [ADDR_W-1:0] IDX_LPA = 8'h05;
	localparam logic [ADDR_W-1:0] IDX_EXP = 8'h06;
	localparam logic [ADDR_W-1:0] IDX_OVR = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_ADV = 8'(IDX_ADV * 4);
	localparam logic [ADDR_W-1:0] ADDR_LPA = 8'(IDX_LPA * 4);
	localparam logic [ADDR_W-1:0] ADDR_EXP = 8'(IDX_EXP * 4);
	localparam logic [ADDR_W-1:0] ADDR_OVR = 8'(IDX_OVR * 4);
	// selector codes
	localparam logic [SEL_W-1:0] SEL_IEEE_8023 = 5'h01;
	localparam logic [SEL_W-1:0] SEL_IEEE_8029 = 5'h02;
	localparam logic [SEL_W-1:0] ADV_SEL_RESET = SEL_IEEE_8023;
	// partner ability fields
	localparam int unsigned LPA_NEXT_PAGE = 15;
	localparam int unsigned LPA_ACK       = 14;
	localparam int unsigned LPA_RFAULT    = 13;
	localparam int unsigned LPA_SEL_CW_W  = 4;
	localparam logic [REG_W-1:0] LPA_KEEP_MASK = 16'hE1FF;
	localparam logic [REG_W-1:0] LPA_RESET     = 16'h0000;
	// expansion fields
	localparam int unsigned EXP_PD_FAULT = 4;
	localparam int unsigned EXP_LP_NP    = 3;
	localparam int unsigned EXP_NP_ABLE  = 2;
	localparam int unsigned EXP_PAGE_RX  = 1;
	localparam int unsigned EXP_LP_AN    = 0;
	localparam logic        NP_ABLE_VAL  = 1'b1;
	// override control
	localparam int unsigned OVR_BIT   = 15;
	localparam logic        OVR_RESET = 1'b0;
endpackage

/* File: anps_lh_flag.sv */
// latching-high status flag, cleared only by a read that saw it set
`timescale 1ns/1ps
`default_nettype none
module anps_lh_flag
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic set_evt,
	input  wire logic clr_req,
	output logic      flag
);
	typedef struct packed
	{
		logic flag;
	} anps_lh_state_t;

	anps_lh_state_t st_reg;
	anps_lh_state_t st_next;

	always_comb
	begin
		st_next = st_reg;
		// set wins over a clear landing in the same cycle
		st_next.flag = set_evt | (st_reg.flag & ~clr_req); // [RULE_20]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign flag = st_reg.flag;
endmodule // anps_lh_flag
`default_nettype wire

/* File: anps_cw_field.sv */
// field whose management writes pass only while override is set
`timescale 1ns/1ps
`default_nettype none
module anps_cw_field
#(
	parameter int unsigned           W     = 5,
	parameter logic [W-1:0]          RESET = '0
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         wr_en,
	input  wire logic         override,
	input  wire logic [W-1:0] wr_data,
	output logic      [W-1:0] value
);
	typedef struct packed
	{
		logic [W-1:0] value;
	} anps_cw_state_t;

	anps_cw_state_t st_reg;
	anps_cw_state_t st_next;

	always_comb
	begin
		st_next = st_reg;
		if (wr_en && override) // [RULE_13]
			st_next.value = wr_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= RESET;
		else
			st_reg <= st_next;
	end

	assign value = st_reg.value;
endmodule // anps_cw_field
`default_nettype wire

/* File: anps_regs_checker.sv */
// assertions on the partner status register bank ports
`timescale 1ns/1ps
`default_nettype none
module anps_regs_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        lcw_valid,
	input wire logic [15:0] lcw_data,
	input wire logic        flp_ok,
	input wire logic        pd_fault,
	input wire logic [4:0]  adv_selector
);
	wire logic rd_lpa = psel && !penable && !pwrite && paddr == 8'h14;
	wire logic rd_exp = psel && !penable && !pwrite && paddr == 8'h18;
	wire logic rd_end = psel && penable && pready && !pwrite;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_sel_reset: assert property ($rose(presetn) |-> adv_selector == 5'h01)
		else $error("selector reset wrong");
	chk_lpa_load: assert property (lcw_valid ##1 rd_lpa |=>
		prdata == {16'h0000, $past(lcw_data, 2) & 16'hE1FF}) else $error("partner word wrong");
	chk_lpa_zero: assert property (rd_end && paddr == 8'h14 |-> prdata[31:16] == 16'h0000 && prdata[12:9] == 4'h0)
		else $error("partner zero bits set");
	chk_exp_fixed: assert property (rd_end && paddr == 8'h18 |-> prdata[31:5] == 27'h0000000 && prdata[2])
		else $error("expansion fixed bits wrong");
	chk_pd_latch: assert property (pd_fault ##1 rd_exp |=> prdata[4])
		else $error("fault flag missed");
	chk_page_rx: assert property (lcw_valid ##1 rd_exp |=> prdata[1])
		else $error("page flag missed");
	chk_np_able: assert property (lcw_valid ##1 rd_exp |=> prdata[3] == $past(lcw_data[15], 2))
		else $error("partner next page wrong");
	chk_rd_clear: assert property (rd_end && paddr == 8'h18 && prdata[1] && !lcw_valid ##1 !lcw_valid ##1 rd_exp
		|=> !prdata[1]) else $error("page flag not cleared");
	chk_flp_lag: assert property (rd_exp |=> prdata[0] == $past(flp_ok, 2))
		else $error("burst flag wrong");
endmodule // anps_regs_checker
bind anps_regs anps_regs_checker anps_regs_checker_i (.*);
`default_nettype wire

/* File: anps_lp_model.sv */
// link partner model: code words, pulse bursts, detection faults
`timescale 1ns/1ps
`default_nettype none
module anps_lp_model
(
	input  wire logic   pclk,
	output logic        lcw_valid = 1'h0,
	output logic [15:0] lcw_data = 16'h0000,
	output logic        flp_ok = 1'h0,
	output logic        pd_fault = 1'h0
);
	task automatic send(input logic [15:0] w);
		@(posedge pclk);
		lcw_valid <= 1'h1;
		lcw_data  <= w;
		@(posedge pclk);
		lcw_valid <= 1'h0;
		// stale word inverted so nothing leans on it
		lcw_data  <= ~w;
	endtask
	task automatic fault;
		@(posedge pclk);
		pd_fault <= 1'h1;
		@(posedge pclk);
		pd_fault <= 1'h0;
	endtask
	task automatic bursts(input logic on);
		@(posedge pclk);
		flp_ok <= on;
		@(posedge pclk);
	endtask
endmodule // anps_lp_model
`default_nettype wire

/* File: tb_top.sv */
// bench for the partner status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready, pslverr, lcw_valid, flp_ok, pd_fault;
	logic [15:0] lcw_data;
	logic [4:0]  adv_selector;
	int          err_total = 0;
	int          n_compared = 0;
	anps_regs anps_regs_i (.*);
	anps_lp_model anps_lp_model_i (.*);
	initial
	begin
		forever #4 pclk = ~pclk;
	end
	task automatic check(input logic ok, input string m);
		n_compared++;
		// an unknown result counts as a mismatch, never as a pass
		if (ok !== 1'h1)
		begin
			$display("wrong value at %0t: %s", $time, m);
			err_total++;
		end
	endtask
	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		// wait as long as the slave asks; only the watchdog ends a hang
		while (pready !== 1'h1)
			@(posedge pclk);
		check(pready === 1'h1 && pslverr === err && (w || prdata === d), "apb transfer");
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, e, 1'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, 1'h0);
	endtask
	initial
	begin
		#20000;
		err_total++;
		close_out;
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		check(adv_selector === 5'h01, "selector reset");
		check(pready === 1'h0 && pslverr === 1'h0 && prdata === 32'h00000000, "bus idle after reset");
		rd(8'h10, 32'h1);
		rd(8'h18, 32'h4);
		anps_lp_model_i.bursts(1'h1);
		anps_lp_model_i.send(16'hFFFF);
		rd(8'h14, 32'hE1FF);
		rd(8'h18, 32'hF);
		rd(8'h18, 32'hD);
		anps_lp_model_i.send(16'h4021);
		rd(8'h18, 32'h7);
		rd(8'h14, 32'h4021);
		anps_lp_model_i.send(16'h8002);
		rd(8'h18, 32'hF);
		rd(8'h14, 32'h8002);
		wr(8'h10, 32'h2);
		wr(8'h14, 32'h1);
		check(adv_selector === 5'h01, "selector guarded");
		rd(8'h14, 32'h8002);
		wr(8'h40, 32'h8000);
		rd(8'h40, 32'h8000);
		wr(8'h10, 32'h2);
		wr(8'h14, 32'h1);
		check(adv_selector === 5'h02, "selector override");
		rd(8'h14, 32'h8001);
		wr(8'h40, 32'h0);
		anps_lp_model_i.fault;
		rd(8'h18, 32'h1D);
		anps_lp_model_i.fault;
		repeat (5) @(posedge pclk);
		rd(8'h18, 32'h1D);
		rd(8'h18, 32'hD);
		anps_lp_model_i.bursts(1'h0);
		rd(8'h18, 32'hC);
		xfer(1'h0, 8'h08, 32'h0, 1'h1);
		close_out;
	end
endmodule // tb_top
`default_nettype wire
